/* upe_map.svh */
/*
  Register offsets, field positions, reset values and keys of the
  page-three enhanced control block. Assumes byte registers in lane 0.
*/
`ifndef UPE_MAP_SVH
`define UPE_MAP_SVH
// ==========================================
// Word offsets (byte address = offset)
`define UPE_OFF_LINE_CTRL   8'h00
`define UPE_OFF_PAGE_SEL    8'h04
`define UPE_OFF_AUTO_TOGGLE 8'h08
`define UPE_OFF_ENH_FEAT    8'h0C
`define UPE_OFF_STOP_CHAR2  8'h10
`define UPE_OFF_UPPER_THR   8'h14
`define UPE_OFF_LOWER_THR   8'h18
`define UPE_OFF_INT_ENABLE  8'h1C
`define UPE_OFF_FIFO_CTRL   8'h20
`define UPE_OFF_MODEM_CTRL  8'h24
`define UPE_OFF_STATUS      8'h28
// ==========================================
// Keys and reset values
`define UPE_EXT_KEY         8'hBF
`define UPE_PAGE_KEY        7'h52
`define UPE_ATR_RST         8'h80
`define UPE_ZERO_RST        8'h00
`define UPE_ATR_MASK        8'hF3
// ==========================================
// Field positions
`define UPE_ATR_RX_POL      7
`define UPE_ATR_RX_MODE     6
`define UPE_ATR_TX_POL      5
`define UPE_ATR_TX_MODE     4
`define UPE_EFR_CTS         7
`define UPE_EFR_RTS         6
`define UPE_EFR_SPECIAL     5
`define UPE_EFR_GATE        4
`define UPE_STAT_SPECIAL    4
// ==========================================
// AXI responses
`define UPE_RESP_OKAY       2'h0
`define UPE_RESP_SLVERR     2'h2
`define UPE_RESP_DECERR     2'h3
`endif

/* upe_pkg.sv */
/*
  Types of the page-three enhanced control block.
  Assumes nothing of its surroundings.
*/
package upe_pkg;
  // ==========================================
  // Transceiver toggle pin assignment, in field order 00..11
  typedef enum logic [1:0] {
    upe_toggle_off,
    upe_toggle_rts,
    upe_toggle_dtr,
    upe_toggle_ready
  } upe_toggle_type;
endpackage

/* upe_toggle_levels.sv */
/*
  Combinational transceiver enable levels from the toggle control byte.
  Assumes tx_active is high while a character is on the serial output.
*/
`timescale 1ns/1ps
`include "upe_map.svh"
module upe_toggle_levels (
  input  wire logic [7:0] toggle_ctrl,  // Auto toggle control byte
  input  wire logic       tx_active,    // Serial output busy
  output logic            transmit_enable_out_level,   // Transmit enable pin level
  output logic            receive_enable_out_level    // Receive enable pin level
);
  // ==========================================
  // Enable levels
  logic tx_assert;  // Transmit enable asserted
  logic rx_assert;  // Receive enable asserted
  // Assertion state, then polarity
  always_comb begin
    tx_assert  = toggle_ctrl[`UPE_ATR_TX_MODE] ? tx_active : 1'b1;
    rx_assert  = 1'b1;
    if ((toggle_ctrl[1:0] == 2'h3) && toggle_ctrl[`UPE_ATR_RX_MODE]) begin
      rx_assert = ~tx_active;
    end
    transmit_enable_out_level = tx_assert ? toggle_ctrl[`UPE_ATR_TX_POL] : ~toggle_ctrl[`UPE_ATR_TX_POL];
    receive_enable_out_level = rx_assert ? toggle_ctrl[`UPE_ATR_RX_POL] : ~toggle_ctrl[`UPE_ATR_RX_POL];
  end
endmodule // upe_toggle_levels

/* upe_rts_hyst.sv */
/*
  Receive FIFO hysteresis for automatic request-to-send.
  Assumes fifo_level counts stored characters, synchronous to aclk.
*/
`timescale 1ns/1ps
module upe_rts_hyst #(
  parameter int LVL_W = 9  // Width of the FIFO level
) (
  input  wire logic             aclk,        // Clock
  input  wire logic             aresetn,     // Sync reset, low
  input  wire logic             ce,          // Clock enable
  input  wire logic             enable,      // Auto request-to-send on
  input  wire logic [LVL_W-1:0] fifo_level,  // RX FIFO occupancy
  input  wire logic [7:0]       upper_thr,   // Upper threshold
  input  wire logic [7:0]       lower_thr,   // Lower threshold
  output logic                  stop_q       // High: far end must stop
);
  // ==========================================
  // Hysteresis state
  logic             stop_d;  // Next stop state
  logic [LVL_W-1:0] up_ext;  // Widened upper threshold
  logic [LVL_W-1:0] lo_ext;  // Widened lower threshold
  // Next state: above upper sets, below lower clears
  always_comb begin
    up_ext = {{(LVL_W-8){1'b0}}, upper_thr};
    lo_ext = {{(LVL_W-8){1'b0}}, lower_thr};
    stop_d = stop_q;
    if (!enable) begin
      stop_d = 1'b0;  // Disabled
    end else if (fifo_level > up_ext) begin
      stop_d = 1'b1;
    end else if (fifo_level < lo_ext) begin
      stop_d = 1'b0;
    end
  end
  // Register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_q <= 1'b0;
    end else if (ce) begin
      stop_q <= stop_d;
    end
  end
endmodule // upe_rts_hyst

/* upe_enhanced_ctrl.sv */
/*
  Page-three enhanced control of one UART channel behind AXI4-Lite:
  gated page select, transceiver auto toggle, enhanced feature bits.
  Assumes all inputs synchronous to aclk; byte registers in lane 0.
*/
`timescale 1ns/1ps
`include "upe_map.svh"
module upe_enhanced_ctrl #(
  parameter int LVL_W = 9  // RX FIFO level width
) (
  input  wire logic             aclk,             // Clock, 40 MHz
  input  wire logic             aresetn,          // Sync reset, low
  input  wire logic             ce,               // Clock enable
  input  wire logic [7:0]       s_axi_awaddr,     // Write address
  input  wire logic [2:0]       s_axi_awprot,     // Unused
  input  wire logic             s_axi_awvalid,    // Write address valid
  output logic                  s_axi_awready,    // Write address ready
  input  wire logic [31:0]      s_axi_wdata,      // Write data
  input  wire logic [3:0]       s_axi_wstrb,      // Byte strobes
  input  wire logic             s_axi_wvalid,     // Write data valid
  output logic                  s_axi_wready,     // Write data ready
  output logic [1:0]            s_axi_bresp,      // Write response
  output logic                  s_axi_bvalid,     // Write response valid
  input  wire logic             s_axi_bready,     // Write response ready
  input  wire logic [7:0]       s_axi_araddr,     // Read address
  input  wire logic [2:0]       s_axi_arprot,     // Unused
  input  wire logic             s_axi_arvalid,    // Read address valid
  output logic                  s_axi_arready,    // Read address ready
  output logic [31:0]           s_axi_rdata,      // Read data
  output logic [1:0]            s_axi_rresp,      // Read response
  output logic                  s_axi_rvalid,     // Read valid
  input  wire logic             s_axi_rready,     // Read ready
  input  wire logic             tx_active,        // Character on serial out
  input  wire logic             cts_n_in,         // Clear-to-send pin
  input  wire logic [LVL_W-1:0] rx_fifo_level,    // RX FIFO occupancy
  input  wire logic             rx_char_valid,    // Received char strobe
  input  wire logic [7:0]       rx_char,          // Received character
  input  wire logic             transmit_ready_pin_core,       // Normal transmit ready
  input  wire logic             receive_ready_pin_core,       // Normal receive ready
  output logic                  rts_n_pin,        // Request-to-send pin
  output logic                  dtr_n_pin,        // Terminal-ready pin
  output logic                  transmit_ready_pin_pin,        // Transmit ready pin
  output logic                  receive_ready_pin_pin,        // Receive ready pin
  output logic                  tx_halt,          // Transmitter must stop
  output logic [3:0]            sw_flow_sel,      // Software flow select
  output logic [7:0]            ier_eff,          // Effective int enables
  output logic [7:0]            fcr_eff,          // Effective FIFO ctrl
  output logic [7:0]            mcr_eff,          // Effective modem ctrl
  output logic                  special_char_hit, // Status bit 4
  output logic                  page4_sel         // Page four chosen
);
  // ==========================================
  // Register file and bus state
  logic [7:0]  lcr_q, lcr_d;      // Line control
  logic        page_q, page_d;    // Page bit
  logic [7:0]  atr_q, atr_d;      // Auto toggle control
  logic [7:0]  efr_q, efr_d;      // Enhanced feature control
  logic [7:0]  ssc_q, ssc_d;      // Second stop character
  logic [7:0]  uthr_q, uthr_d;    // Upper flow threshold
  logic [7:0]  lthr_q, lthr_d;    // Lower flow threshold
  logic [7:0]  ier_q, ier_d;      // Interrupt enable
  logic [7:0]  fcr_q, fcr_d;      // FIFO control
  logic [7:0]  mcr_q, mcr_d;      // Modem control
  logic        sc_q, sc_d;        // Special char sticky
  logic        aw_full_q, aw_full_d;  // Address held
  logic [7:0]  aw_addr_q, aw_addr_d;  // Held address
  logic        w_full_q, w_full_d;    // Data held
  logic [7:0]  w_data_q, w_data_d;    // Held data byte
  logic        w_lane_q, w_lane_d;    // Lane 0 strobe
  logic        awrdy_q, awrdy_d;      // Address ready
  logic        wrdy_q, wrdy_d;        // Data ready
  logic        bval_q, bval_d;        // Response valid
  logic [1:0]  bresp_q, bresp_d;      // Write response
  logic        arrdy_q, arrdy_d;      // Read address ready
  logic        rval_q, rval_d;        // Read valid
  logic [1:0]  rresp_q, rresp_d;      // Read response
  logic [31:0] rdata_q, rdata_d;      // Read data
  logic        wr_fire;               // Write performed this cycle
  logic        ext_ok;                // Extended pages open
  logic [1:0]  wr_acc;                // Write access verdict
  logic [1:0]  rd_acc;                // Read access verdict
  logic        rts_stop;              // Auto request-to-send state

  assign ext_ok  = (lcr_q == `UPE_EXT_KEY);
  assign wr_fire = aw_full_q && w_full_q && !bval_q;

  // Access verdict for an offset
  function automatic logic [1:0] acc_check(input logic [7:0] a);
    unique case (a)
      `UPE_OFF_LINE_CTRL, `UPE_OFF_INT_ENABLE, `UPE_OFF_FIFO_CTRL,
      `UPE_OFF_MODEM_CTRL, `UPE_OFF_STATUS:
        acc_check = `UPE_RESP_OKAY;
      `UPE_OFF_PAGE_SEL:  // Reachable from both pages
        acc_check = ext_ok ? `UPE_RESP_OKAY : `UPE_RESP_SLVERR;
      `UPE_OFF_AUTO_TOGGLE, `UPE_OFF_ENH_FEAT, `UPE_OFF_STOP_CHAR2:
        acc_check = (ext_ok && !page_q) ? `UPE_RESP_OKAY : `UPE_RESP_SLVERR;
      `UPE_OFF_UPPER_THR, `UPE_OFF_LOWER_THR:
        acc_check = (ext_ok && page_q) ? `UPE_RESP_OKAY : `UPE_RESP_SLVERR;
      default:
        acc_check = `UPE_RESP_DECERR;
    endcase
  endfunction

  // ==========================================
  // Bus and register next state
  always_comb begin
    lcr_d = lcr_q;  page_d = page_q;  atr_d = atr_q;  efr_d = efr_q;
    ssc_d = ssc_q;  uthr_d = uthr_q;  lthr_d = lthr_q;
    ier_d = ier_q;  fcr_d = fcr_q;  mcr_d = mcr_q;  sc_d = sc_q;
    aw_full_d = aw_full_q;  aw_addr_d = aw_addr_q;
    w_full_d = w_full_q;  w_data_d = w_data_q;  w_lane_d = w_lane_q;
    bval_d = bval_q;  bresp_d = bresp_q;
    rval_d = rval_q;  rresp_d = rresp_q;  rdata_d = rdata_q;
    wr_acc = acc_check(aw_addr_q);
    rd_acc = acc_check(s_axi_araddr);
    // Response taken
    if (bval_q && s_axi_bready) begin
      bval_d = 1'b0;
    end
    // Perform held write
    if (wr_fire) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bval_d    = 1'b1;
      bresp_d   = wr_acc;
      if ((wr_acc == `UPE_RESP_OKAY) && w_lane_q) begin
        unique case (aw_addr_q)
          `UPE_OFF_LINE_CTRL:   lcr_d = w_data_q;
          `UPE_OFF_PAGE_SEL: begin
            if (w_data_q[7:1] == `UPE_PAGE_KEY) begin
              page_d = w_data_q[0];
            end  // Wrong key: nothing changes
          end
          `UPE_OFF_AUTO_TOGGLE: atr_d = w_data_q & `UPE_ATR_MASK;
          `UPE_OFF_ENH_FEAT:    efr_d = w_data_q;
          `UPE_OFF_STOP_CHAR2:  ssc_d = w_data_q;
          `UPE_OFF_UPPER_THR:   uthr_d = w_data_q;
          `UPE_OFF_LOWER_THR:   lthr_d = w_data_q;
          `UPE_OFF_INT_ENABLE:  // Upper nibble gated
            ier_d = efr_q[`UPE_EFR_GATE] ? w_data_q : {ier_q[7:4], w_data_q[3:0]};
          `UPE_OFF_FIFO_CTRL:   // Bits 5:4 gated
            fcr_d = efr_q[`UPE_EFR_GATE] ? w_data_q : {w_data_q[7:6], fcr_q[5:4], w_data_q[3:0]};
          `UPE_OFF_MODEM_CTRL:  // Bits 7:5 gated
            mcr_d = efr_q[`UPE_EFR_GATE] ? w_data_q : {mcr_q[7:5], w_data_q[4:0]};
          `UPE_OFF_STATUS:      sc_d = sc_q & ~w_data_q[`UPE_STAT_SPECIAL];
          default:              sc_d = sc_q;
        endcase
      end
    end
    // Capture address and data, either order
    if (s_axi_awvalid && awrdy_q) begin
      aw_full_d = 1'b1;
      aw_addr_d = {s_axi_awaddr[7:2], 2'h0};
    end
    if (s_axi_wvalid && wrdy_q) begin
      w_full_d = 1'b1;
      w_data_d = s_axi_wdata[7:0];
      w_lane_d = s_axi_wstrb[0];
    end
    // Read channel
    if (rval_q && s_axi_rready) begin
      rval_d = 1'b0;
    end
    if (s_axi_arvalid && arrdy_q) begin
      rval_d  = 1'b1;
      rresp_d = rd_acc;
      rdata_d = 32'h0000_0000;
      if (rd_acc == `UPE_RESP_OKAY) begin
        unique case ({s_axi_araddr[7:2], 2'h0})
          `UPE_OFF_LINE_CTRL:   rdata_d[7:0] = lcr_q;
          `UPE_OFF_PAGE_SEL:    rdata_d[7:0] = {7'h00, page_q};
          `UPE_OFF_AUTO_TOGGLE: rdata_d[7:0] = atr_q;
          `UPE_OFF_ENH_FEAT:    rdata_d[7:0] = efr_q;
          `UPE_OFF_STOP_CHAR2:  rdata_d[7:0] = ssc_q;
          `UPE_OFF_UPPER_THR:   rdata_d[7:0] = uthr_q;
          `UPE_OFF_LOWER_THR:   rdata_d[7:0] = lthr_q;
          `UPE_OFF_INT_ENABLE:  rdata_d[7:0] = ier_q;
          `UPE_OFF_FIFO_CTRL:   rdata_d[7:0] = fcr_q;
          `UPE_OFF_MODEM_CTRL:  rdata_d[7:0] = mcr_q;
          `UPE_OFF_STATUS:      rdata_d[7:0] = {3'h0, sc_q, 1'b0, page_q, tx_halt, rts_stop};
          default:              rdata_d = 32'h0000_0000;
        endcase
      end
    end
    // Special character detect, set wins over clear
    if (efr_q[`UPE_EFR_SPECIAL] && rx_char_valid && (rx_char == ssc_q)) begin
      sc_d = 1'b1;
    end
    awrdy_d = !aw_full_d;
    wrdy_d  = !w_full_d;
    arrdy_d = !rval_d;
  end

  // Register bus and register file
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lcr_q <= `UPE_ZERO_RST;  page_q <= 1'b0;  atr_q <= `UPE_ATR_RST;
      efr_q <= `UPE_ZERO_RST;  ssc_q <= `UPE_ZERO_RST;
      uthr_q <= `UPE_ZERO_RST;  lthr_q <= `UPE_ZERO_RST;
      ier_q <= `UPE_ZERO_RST;  fcr_q <= `UPE_ZERO_RST;
      mcr_q <= `UPE_ZERO_RST;  sc_q <= 1'b0;
      aw_full_q <= 1'b0;  aw_addr_q <= 8'h00;
      w_full_q <= 1'b0;  w_data_q <= 8'h00;  w_lane_q <= 1'b0;
      awrdy_q <= 1'b0;  wrdy_q <= 1'b0;  arrdy_q <= 1'b0;
      bval_q <= 1'b0;  bresp_q <= `UPE_RESP_OKAY;
      rval_q <= 1'b0;  rresp_q <= `UPE_RESP_OKAY;  rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      lcr_q <= lcr_d;  page_q <= page_d;  atr_q <= atr_d;  efr_q <= efr_d;
      ssc_q <= ssc_d;  uthr_q <= uthr_d;  lthr_q <= lthr_d;
      ier_q <= ier_d;  fcr_q <= fcr_d;  mcr_q <= mcr_d;  sc_q <= sc_d;
      aw_full_q <= aw_full_d;  aw_addr_q <= aw_addr_d;
      w_full_q <= w_full_d;  w_data_q <= w_data_d;  w_lane_q <= w_lane_d;
      awrdy_q <= awrdy_d;  wrdy_q <= wrdy_d;  arrdy_q <= arrdy_d;
      bval_q <= bval_d;  bresp_q <= bresp_d;
      rval_q <= rval_d;  rresp_q <= rresp_d;  rdata_q <= rdata_d;
    end
  end

  assign s_axi_awready = awrdy_q;
  assign s_axi_wready  = wrdy_q;
  assign s_axi_bvalid  = bval_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arrdy_q;
  assign s_axi_rvalid  = rval_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  // ==========================================
  // Flow control and transceiver toggling
  logic transmit_enable_out_lvl;   // Transmit enable level
  logic receive_enable_out_lvl;   // Receive enable level
  logic rts_norm;   // Normal request-to-send level
  logic dtr_norm;   // Normal terminal-ready level
  logic rts_d, dtr_d, txr_d, rxr_d, halt_d;  // Next pin values
  upe_pkg::upe_toggle_type tmode;            // Pin assignment

  upe_rts_hyst #(.LVL_W(LVL_W)) u_hyst (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ce         (ce),
    .enable     (efr_q[`UPE_EFR_RTS]),
    .fifo_level (rx_fifo_level),
    .upper_thr  (uthr_q),
    .lower_thr  (lthr_q),
    .stop_q     (rts_stop)
  );

  upe_toggle_levels u_tgl (
    .toggle_ctrl (atr_q),
    .tx_active   (tx_active),
    .transmit_enable_out_level  (transmit_enable_out_lvl),
    .receive_enable_out_level  (receive_enable_out_lvl)
  );

  // Pin multiplexing by toggle field
  always_comb begin
    tmode    = upe_pkg::upe_toggle_type'(atr_q[1:0]);
    rts_norm = efr_q[`UPE_EFR_RTS] ? rts_stop : ~mcr_q[1];
    dtr_norm = ~mcr_q[0];
    rts_d    = rts_norm;
    dtr_d    = dtr_norm;
    txr_d    = transmit_ready_pin_core;
    rxr_d    = receive_ready_pin_core;
    halt_d   = efr_q[`UPE_EFR_CTS] && cts_n_in;
    unique case (tmode)
      upe_pkg::upe_toggle_off:   rts_d = rts_norm;
      upe_pkg::upe_toggle_rts:   rts_d = transmit_enable_out_lvl;
      upe_pkg::upe_toggle_dtr:   dtr_d = transmit_enable_out_lvl;
      upe_pkg::upe_toggle_ready: begin
        txr_d = transmit_enable_out_lvl;
        rxr_d = receive_enable_out_lvl;
      end
    endcase
  end

  // Pin and effective-value registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rts_n_pin <= 1'b1;  dtr_n_pin <= 1'b1;
      transmit_ready_pin_pin <= 1'b0;  receive_ready_pin_pin <= 1'b0;  tx_halt <= 1'b0;
      sw_flow_sel <= 4'h0;  ier_eff <= 8'h00;  fcr_eff <= 8'h00;
      mcr_eff <= 8'h00;  special_char_hit <= 1'b0;  page4_sel <= 1'b0;
    end else if (ce) begin
      rts_n_pin <= rts_d;  dtr_n_pin <= dtr_d;
      transmit_ready_pin_pin <= txr_d;  receive_ready_pin_pin <= rxr_d;  tx_halt <= halt_d;
      sw_flow_sel <= efr_q[3:0];
      ier_eff <= efr_q[`UPE_EFR_GATE] ? ier_q : {4'h0, ier_q[3:0]};
      fcr_eff <= efr_q[`UPE_EFR_GATE] ? fcr_q : {fcr_q[7:6], 2'h0, fcr_q[3:0]};
      mcr_eff <= efr_q[`UPE_EFR_GATE] ? mcr_q : {3'h0, mcr_q[4:0]};
      special_char_hit <= sc_q;
      page4_sel <= page_q;
    end
  end

  // ==========================================
  // Assertions
  a_ext_lock: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && wr_fire && (aw_addr_q == `UPE_OFF_AUTO_TOGGLE) && !ext_ok |=> $stable(atr_q))
    else $error("toggle control written while pages locked");
  a_key_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && wr_fire && (aw_addr_q == `UPE_OFF_PAGE_SEL) && (w_data_q[7:1] != `UPE_PAGE_KEY)
    |=> $stable(page_q))
    else $error("page changed without key");
  a_psr_read_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && s_axi_arvalid && arrdy_q && ext_ok && (s_axi_araddr == `UPE_OFF_PAGE_SEL)
    |=> s_axi_rvalid && (s_axi_rdata[7:1] == 7'h00))
    else $error("page select upper bits not zero");
  a_atr_zero_bits: assert property (@(posedge aclk) disable iff (!aresetn)
    atr_q[3:2] == 2'h0)
    else $error("toggle bits 3:2 not zero");
  a_cts_halt: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && efr_q[`UPE_EFR_CTS] && cts_n_in |=> tx_halt)
    else $error("transmit not halted by clear-to-send");
  a_efr_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && wr_fire && (aw_addr_q == `UPE_OFF_INT_ENABLE) && !efr_q[`UPE_EFR_GATE]
    |=> $stable(ier_q[7:4]))
    else $error("gated enable bits written");
  a_special_set: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && efr_q[`UPE_EFR_SPECIAL] && rx_char_valid && (rx_char == ssc_q) |=> sc_q)
    else $error("special character not flagged");
  a_rts_transmit_enable_out: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && (atr_q[1:0] == 2'h1) |=> rts_n_pin == $past(transmit_enable_out_lvl))
    else $error("request pin not carrying transmit enable");
  a_idle_pins: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && (atr_q[1:0] == 2'h0) |=> (rts_n_pin == $past(rts_norm)) && (transmit_ready_pin_pin == $past(transmit_ready_pin_core)))
    else $error("pins not normal with toggle off");
endmodule // upe_enhanced_ctrl

/* upe_line_model.sv */
/*
  Line-side partner: transmitter activity and far-end clear-to-send.
  Assumes start is a one-clock pulse from the bench.
*/
`timescale 1ns/1ps
module upe_line_model #(
  parameter int CHAR_CYC = 10  // Clocks per character
) (
  input  wire logic aclk,      // Clock
  input  wire logic aresetn,   // Sync reset, low
  input  wire logic start,     // Begin one character
  input  wire logic far_busy,  // Far end cannot take data
  output logic      tx_active, // Character on serial out
  output logic      cts_n      // Clear-to-send, high means stop
);
  // ==========================================
  // Character timer
  int cnt_q;  // Clocks left in character
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_q <= 0;
    else if (start) cnt_q <= CHAR_CYC;
    else if (cnt_q > 0) cnt_q <= cnt_q - 1;
  end
  assign tx_active = (cnt_q > 0);
  // Far end holds the line high to stop us
  assign cts_n = far_busy;
endmodule // upe_line_model

/* uart_page3_enhanced_ctrl_tb.sv */
/*
  Self-checking bench of the enhanced control block.
  Assumes upe_map.svh on the include path and the line partner.
*/
`timescale 1ns/1ps
`include "upe_map.svh"
module uart_page3_enhanced_ctrl_tb;
  // ==========================================
  // Signals, same names as the ports
  logic aclk = 0, aresetn = 0, ce = 1, start = 0, far_busy = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, rx_char = 0;
  logic [2:0]  s_axi_awprot = 0, s_axi_arprot = 0;
  logic [3:0]  s_axi_wstrb = 4'h1, sw_flow_sel;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [8:0]  rx_fifo_level = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, rx_char_valid = 0;
  logic transmit_ready_pin_core = 0, receive_ready_pin_core = 0, tx_active, cts_n_in;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, rts_n_pin, dtr_n_pin, transmit_ready_pin_pin, receive_ready_pin_pin;
  logic tx_halt, special_char_hit, page4_sel;
  logic [7:0] ier_eff, fcr_eff, mcr_eff;
  int err_total = 0, checks_done = 0;
  wire logic [3:0] pins = {receive_ready_pin_pin, transmit_ready_pin_pin, dtr_n_pin, rts_n_pin};
  upe_enhanced_ctrl #(.LVL_W(9)) i_upe_enhanced_ctrl (.*);
  upe_line_model i_upe_line_model (.aclk, .aresetn, .start, .far_busy,
    .tx_active, .cts_n(cts_n_in));
  // ==========================================
  // Clock, 25 ns
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  // ==========================================
  // Helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic st();
    repeat (3) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk(s_axi_rresp, r);
    chk(s_axi_rdata, {24'h00_0000, d});
  endtask
  // Toggle byte, then pin level idle and while sending
  task automatic tg(input logic [7:0] t, input int i, input logic idl, input logic bsy);
    wr(8'h08, t, `UPE_RESP_OKAY);
    st();
    chk(pins[i], idl);
    start <= 1'h1;
    @(posedge aclk);
    start <= 1'h0;
    st();
    chk(pins[i], bsy);
    repeat (10) @(posedge aclk);
  endtask
  // FIFO level, then request pin level once settled
  task automatic lv(input logic [8:0] l, input logic e);
    rx_fifo_level <= l;
    st();
    chk(rts_n_pin, e);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_page();
    wr(8'h08, 8'h00, `UPE_RESP_SLVERR);
    rd(8'h08, 8'h00, `UPE_RESP_SLVERR);
    rd(8'h3c, 8'h00, `UPE_RESP_DECERR);
    wr(8'h00, 8'hbf, `UPE_RESP_OKAY);
    rd(8'h08, 8'h80, `UPE_RESP_OKAY);
    wr(8'h04, 8'h01, `UPE_RESP_OKAY);
    rd(8'h04, 8'h00, `UPE_RESP_OKAY);
    wr(8'h04, 8'ha5, `UPE_RESP_OKAY);
    rd(8'h04, 8'h01, `UPE_RESP_OKAY);
    chk(page4_sel, 1'h1);
    rd(8'h0c, 8'h00, `UPE_RESP_SLVERR);
    wr(8'h04, 8'ha4, `UPE_RESP_OKAY);
    rd(8'h04, 8'h00, `UPE_RESP_OKAY);
    $display("test page done");
  endtask
  task automatic t_tog();
    transmit_ready_pin_core <= 1'h1;
    wr(8'h08, 8'hff, `UPE_RESP_OKAY);
    rd(8'h08, 8'hf3, `UPE_RESP_OKAY);
    tg(8'h31, 0, 1'h0, 1'h1);
    tg(8'h31, 1, 1'h1, 1'h1);
    tg(8'h02, 1, 1'h0, 1'h0);
    tg(8'h22, 0, 1'h1, 1'h1);
    tg(8'h13, 2, 1'h1, 1'h0);
    tg(8'hc3, 3, 1'h1, 1'h0);
    tg(8'h43, 3, 1'h0, 1'h1);
    tg(8'h83, 3, 1'h1, 1'h1);
    tg(8'h30, 0, 1'h1, 1'h1);
    tg(8'h30, 2, 1'h1, 1'h1);
    $display("test toggle done");
  endtask
  task automatic t_feat();
    wr(8'h0c, 8'h8a, `UPE_RESP_OKAY);
    far_busy <= 1'h1;
    st();
    chk(sw_flow_sel, 4'ha);
    chk(tx_halt, 1'h1);
    far_busy <= 1'h0;
    st();
    chk(tx_halt, 1'h0);
    wr(8'h24, 8'he3, `UPE_RESP_OKAY);
    st();
    chk(mcr_eff, 8'h03);
    wr(8'h0c, 8'h30, `UPE_RESP_OKAY);
    wr(8'h24, 8'he3, `UPE_RESP_OKAY);
    wr(8'h10, 8'h55, `UPE_RESP_OKAY);
    st();
    chk(mcr_eff, 8'he3);
    rx_char <= 8'h54;
    rx_char_valid <= 1'h1;
    @(posedge aclk);
    rx_char_valid <= 1'h0;
    st();
    chk(special_char_hit, 1'h0);
    rx_char <= 8'h55;
    rx_char_valid <= 1'h1;
    @(posedge aclk);
    rx_char_valid <= 1'h0;
    st();
    chk(special_char_hit, 1'h1);
    $display("test feature done");
  endtask
  // Gated enables, auto request-to-send hysteresis, status, clock enable
  task automatic t_flow();
    wr(8'h1c, 8'hf5, `UPE_RESP_OKAY);
    wr(8'h20, 8'h3c, `UPE_RESP_OKAY);
    wr(8'h0c, 8'h40, `UPE_RESP_OKAY);
    st();
    chk(ier_eff, 8'h05);
    chk(fcr_eff, 8'h0c);
    wr(8'h1c, 8'h0a, `UPE_RESP_OKAY);
    rd(8'h1c, 8'hfa, `UPE_RESP_OKAY);
    wr(8'h04, 8'ha5, `UPE_RESP_OKAY);
    wr(8'h14, 8'h04, `UPE_RESP_OKAY);
    wr(8'h18, 8'h02, `UPE_RESP_OKAY);
    lv(9'h005, 1'h1);
    rd(8'h28, 8'h15, `UPE_RESP_OKAY);
    wr(8'h28, 8'h10, `UPE_RESP_OKAY);
    rd(8'h28, 8'h05, `UPE_RESP_OKAY);
    lv(9'h003, 1'h1);
    lv(9'h001, 1'h0);
    ce <= 1'h0;
    lv(9'h005, 1'h0);
    ce <= 1'h1;
    st();
    chk(rts_n_pin, 1'h1);
    $display("test flow done");
  endtask
  // ==========================================
  // Verdict, single exit point
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    end_sim();
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    t_page();
    t_tog();
    t_feat();
    t_flow();
    end_sim();
  end
endmodule // uart_page3_enhanced_ctrl_tb
